// [logic/pheiu_defines.svh]
// Purpose: offsets, field positions, reset values of the event interrupt unit
// Assumes: byte addresses on a 32-bit Wishbone bus, index times four
// Notes:   register indices kept as printed, byte address derived
`ifndef PHEIU_DEFINES_SVH
`define PHEIU_DEFINES_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define PHEIU_IDX_MASK      6'h12
`define PHEIU_IDX_STATUS    6'h13
`define PHEIU_IDX_EVENT_IRQ 6'h1E
`define PHEIU_IDX_EVENT_MSK 6'h1F
`define PHEIU_ADDR_MASK      8'h48
`define PHEIU_ADDR_STATUS    8'h4C
`define PHEIU_ADDR_EVENT_IRQ 8'h78
`define PHEIU_ADDR_EVENT_MSK 8'h7C

// ****************************************************************
// field positions, mask register
// ****************************************************************
`define PHEIU_BIT_NEG_MASK    7
`define PHEIU_BIT_RATE_MASK   6
`define PHEIU_BIT_HF_MASK     5
`define PHEIU_BIT_LINK_MASK   4
`define PHEIU_BIT_GLOBAL_EN   1
`define PHEIU_BIT_TEST_FORCE  0
`define PHEIU_MASK_RW_BITS    16'h01FF

// ****************************************************************
// field positions, status register
// ****************************************************************
`define PHEIU_BIT_NEG_FLAG    7
`define PHEIU_BIT_RATE_FLAG   6
`define PHEIU_BIT_HF_FLAG     5
`define PHEIU_BIT_LINK_FLAG   4
`define PHEIU_BIT_PENDING     2

// ****************************************************************
// reset values
// ****************************************************************
`define PHEIU_MASK_RESET      16'h0000
`define PHEIU_FLAGS_RESET     4'h0
`define PHEIU_NUM_EVENTS      4

`endif

// [logic/pheiu_pkg.sv]
// Purpose: types shared by the event interrupt unit files
// Assumes: four link events in fixed order
// Notes:   event vector order is link, half_full, rate, negotiation
package pheiu_pkg;

    // ****************************************************************
    // event vector, one bit per link event
    // ****************************************************************
    typedef struct packed {
        logic negotiation_done;  // negotiation completed
        logic rate_change;       // speed changed
        logic half_full_change;  // duplex changed
        logic link_change;       // link state changed
    } pheiu_events_t;

    // ****************************************************************
    // control bits of the mask register
    // ****************************************************************
    typedef struct packed {
        pheiu_events_t event_mask;        // per-event masks
        logic          global_irq_enable; // global enable
        logic          test_irq_force;    // force interrupt
    } pheiu_ctrl_t;

    // bus slave state
    typedef enum logic [0:0] {
        PHEIU_IDLE,
        PHEIU_ACK
    } pheiu_bus_state_t;

endpackage : pheiu_pkg

// [logic/pheiu_event_latch.sv]
// Purpose: sticky event flags cleared by a status read
// Assumes: event pulses on sys_clk_i, one cycle each
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`include "pheiu_defines.svh"

module pheiu_event_latch #(
    parameter int WIDTH = `PHEIU_NUM_EVENTS  // number of flags
) (
    input  wire logic             sys_clk_i,   // device clock
    input  wire logic             reset_i,     // sync reset, high
    input  wire logic [WIDTH-1:0] set_i,       // event pulses
    input  wire logic             clear_i,     // status read pulse
    output logic      [WIDTH-1:0] flags_o      // latched flags
);

    // ****************************************************************
    // one sticky flag per event
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_flag
            // set wins over read clear
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    flags_o[g] <= 1'b0;
                end else if (set_i[g]) begin
                    flags_o[g] <= 1'b1;
                end else if (clear_i) begin
                    flags_o[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : pheiu_event_latch

// [logic/pheiu_irq_unit.sv]
// Purpose: event interrupt unit of a dual-speed transceiver, Wishbone slave
// Assumes: link state inputs come from outside the clock domain
// Notes:   all registers answer one cycle after the request is seen
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "pheiu_defines.svh"

module pheiu_irq_unit (
    input  wire logic        sys_clk_i,     // device clock, 10 MHz
    input  wire logic        reset_i,       // sync reset, active high
    input  wire logic        wb_cyc_i,      // bus cycle
    input  wire logic        wb_stb_i,      // strobe
    input  wire logic        wb_we_i,       // write enable
    input  wire logic [7:0]  wb_adr_i,      // byte address
    input  wire logic [3:0]  wb_sel_i,      // byte lanes
    input  wire logic [31:0] wb_dat_i,      // write data
    output logic      [31:0] wb_dat_o,      // read data
    output logic             wb_ack_o,      // acknowledge
    output logic             wb_err_o,      // unmapped address
    input  wire logic        neg_done_i,    // negotiation complete level
    input  wire logic        rate_fast_i,   // operating speed level
    input  wire logic        full_duplex_i, // duplex level
    input  wire logic        link_up_i,     // link state level
    output logic             mgmt_irq_o,    // management interrupt, high
    output logic             event_irq_o    // unit event interrupt, high
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [3:0]                 sync1_reg;      // first sync stage
    logic [3:0]                 sync2_reg;      // second sync stage
    logic [3:0]                 prev_reg;       // last seen levels
    logic [1:0]                 prime_cnt_reg;  // edges since reset
    logic                       primed;         // change compare armed
    logic [3:0]                 event_set;      // event pulses
    pheiu_pkg::pheiu_events_t   flags;          // latched flags
    pheiu_pkg::pheiu_ctrl_t     ctrl_reg;       // mask register fields
    logic [15:0]                mask_reg;       // full mask register
    logic                       pending;        // interrupt pending
    pheiu_pkg::pheiu_bus_state_t bus_state_reg; // bus slave state
    logic                       req;            // new request
    logic                       status_read;    // status read pulse
    logic [1:0]                 uevt_reg;       // unit sticky events
    logic [1:0]                 uevt_mask_reg;  // unit event mask
    logic [1:0]                 uevt_set;       // unit event pulses
    logic                       pending_prev_reg; // pending delayed

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic [2:0] decode(input logic [7:0] adr);
        // one-hot-ish index: 1 mask, 2 status, 3 ev irq, 4 ev mask
        unique case (adr)
            `PHEIU_ADDR_MASK:      decode = 3'h1;
            `PHEIU_ADDR_STATUS:    decode = 3'h2;
            `PHEIU_ADDR_EVENT_IRQ: decode = 3'h3;
            `PHEIU_ADDR_EVENT_MSK: decode = 3'h4;
            default:               decode = 3'h0;
        endcase
    endfunction : decode

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // two flops per link level before any logic reads it
    // levels come from another clock; only sync2 reads sync1
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {neg_done_i, rate_fast_i, full_duplex_i,
                          link_up_i};
            sync2_reg <= sync1_reg;
        end
    end

    // ****************************************************************
    // event detection
    // ****************************************************************
    // remember last level for the change compare
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prev_reg <= 4'h0;
        end else begin
            prev_reg <= sync2_reg;
        end
    end

    // counts the edges that refill sync1, sync2 and prev;
    // before that the compare sees reset zeros against live
    // levels and would latch a false change per high input
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prime_cnt_reg <= 2'h0;
        end else if (prime_cnt_reg != 2'h3) begin
            // saturates: stays armed until the next reset
            prime_cnt_reg <= prime_cnt_reg + 2'h1;
        end
    end

    // armed once both compare inputs hold real samples
    assign primed = (prime_cnt_reg == 2'h3);

    // change events for speed, duplex, link; rising edge for negotiation
    always_comb begin
        event_set[3] = primed & sync2_reg[3] & ~prev_reg[3];
        event_set[2] = primed & (sync2_reg[2] ^ prev_reg[2]);
        event_set[1] = primed & (sync2_reg[1] ^ prev_reg[1]);
        event_set[0] = primed & (sync2_reg[0] ^ prev_reg[0]);
    end

    // ****************************************************************
    // sticky status flags
    // ****************************************************************
    // flags clear on status read only; writes never reach them
    pheiu_event_latch #(
        .WIDTH (`PHEIU_NUM_EVENTS)
    ) u_flags (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .set_i     (event_set),
        .clear_i   (status_read),
        .flags_o   (flags)
    );

    // ****************************************************************
    // pending logic
    // ****************************************************************
    // masked flags under global enable, or forced by test bit
    // one value feeds the status read and the output flop,
    // so the pending bit and the pin agree on every edge
    always_comb begin
        pending = (ctrl_reg.global_irq_enable
                   & |(flags & ctrl_reg.event_mask))
                  | ctrl_reg.test_irq_force;
    end

    // interrupt output from a flop
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mgmt_irq_o <= 1'b0;
        end else begin
            mgmt_irq_o <= pending;
        end
    end

    // ****************************************************************
    // bus slave
    // ****************************************************************
    // taken only while idle, so a master that holds stb
    // through the ack cycle is not answered twice
    assign req         = wb_cyc_i & wb_stb_i
                         & (bus_state_reg == pheiu_pkg::PHEIU_IDLE);
    // clear rides the take edge; an event on it still sets
    assign status_read = req & ~wb_we_i
                         & (decode(wb_adr_i) == 3'h2);

    // one ack per request, dropped in the next cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            bus_state_reg <= pheiu_pkg::PHEIU_IDLE;
            wb_ack_o      <= 1'b0;
            wb_err_o      <= 1'b0;
        end else begin
            unique case (bus_state_reg)
                pheiu_pkg::PHEIU_IDLE: begin
                    // answer mapped with ack, unmapped with err
                    wb_ack_o <= req & (decode(wb_adr_i) != 3'h0);
                    wb_err_o <= req & (decode(wb_adr_i) == 3'h0);
                    if (req) begin
                        bus_state_reg <= pheiu_pkg::PHEIU_ACK;
                    end
                end
                pheiu_pkg::PHEIU_ACK: begin
                    // ack falls even if stb is still held
                    wb_ack_o      <= 1'b0;
                    wb_err_o      <= 1'b0;
                    bus_state_reg <= pheiu_pkg::PHEIU_IDLE;
                end
            endcase
        end
    end

    // read data registered with the request; reserved bits read zero except mask bits 8, 3 and 2
    // upper half always zero: each register is 16 bits wide
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req & ~wb_we_i) begin
            unique case (decode(wb_adr_i))
                3'h1:    wb_dat_o <= {16'h0000, mask_reg};
                3'h2:    wb_dat_o <= {16'h0000, 8'h00, flags, 1'b0,
                                      pending, 2'b00};
                3'h3:    wb_dat_o <= {30'h00000000, uevt_reg};
                3'h4:    wb_dat_o <= {30'h00000000, uevt_mask_reg};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end else begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // ****************************************************************
    // mask register
    // ****************************************************************
    // all defined bits reset to zero; reserved bits 8, 3 and 2 stored as written, 15:9 held at zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mask_reg <= `PHEIU_MASK_RESET;
        end else if (req & wb_we_i & (decode(wb_adr_i) == 3'h1)) begin
            // byte lanes 0 and 1 carry the 16-bit register
            if (wb_sel_i[0]) begin
                mask_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                // only bit 8 is stored; bits 15:9 always read zero
                // whatever software puts on the high lane
                mask_reg[15:8] <= wb_dat_i[15:8]
                                  & 8'(`PHEIU_MASK_RW_BITS >> 8);
            end
        end
    end

    // decode the mask register into its fields
    always_comb begin
        ctrl_reg.event_mask.negotiation_done =
            mask_reg[`PHEIU_BIT_NEG_MASK];
        ctrl_reg.event_mask.rate_change =
            mask_reg[`PHEIU_BIT_RATE_MASK];
        ctrl_reg.event_mask.half_full_change =
            mask_reg[`PHEIU_BIT_HF_MASK];
        ctrl_reg.event_mask.link_change =
            mask_reg[`PHEIU_BIT_LINK_MASK];
        ctrl_reg.global_irq_enable = mask_reg[`PHEIU_BIT_GLOBAL_EN];
        ctrl_reg.test_irq_force    = mask_reg[`PHEIU_BIT_TEST_FORCE];
    end

    // ****************************************************************
    // unit event interrupt
    // ****************************************************************
    // events: bit0 pending rose, bit1 any flag event
    // a forced interrupt also counts as a pending rise
    always_comb begin
        uevt_set[0] = pending & ~pending_prev_reg;
        uevt_set[1] = |event_set;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pending_prev_reg <= 1'b0;
        end else begin
            pending_prev_reg <= pending;
        end
    end

    // sticky bits, read clears, set wins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            uevt_reg <= 2'b00;
        end else if (req & ~wb_we_i & (decode(wb_adr_i) == 3'h3)) begin
            uevt_reg <= uevt_set;
        end else begin
            uevt_reg <= uevt_reg | uevt_set;
        end
    end

    // mask of same layout
    // only lane 0 carries the two mask bits
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            uevt_mask_reg <= 2'b00;
        end else if (req & wb_we_i & wb_sel_i[0]
                     & (decode(wb_adr_i) == 3'h4)) begin
            uevt_mask_reg <= wb_dat_i[1:0];
        end
    end

    // level output from a flop
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            event_irq_o <= 1'b0;
        end else begin
            event_irq_o <= |(uevt_reg & uevt_mask_reg);
        end
    end

endmodule : pheiu_irq_unit

// [verif/pheiu_irq_unit_assertions.sv]
// Purpose: port-level checks of the event interrupt unit
// Assumes: mask writes always carry both low byte lanes
// Notes:   shadows the mask register from acknowledged writes
`timescale 1ns/1ps
`include "pheiu_defines.svh"
module pheiu_irq_checker (
    input wire logic        sys_clk_i,     // clock
    input wire logic        reset_i,       // reset
    input wire logic        wb_cyc_i,      // cycle
    input wire logic        wb_stb_i,      // strobe
    input wire logic        wb_we_i,       // write
    input wire logic [7:0]  wb_adr_i,      // address
    input wire logic [3:0]  wb_sel_i,      // lanes
    input wire logic [31:0] wb_dat_i,      // write data
    input wire logic [31:0] wb_dat_o,      // read data
    input wire logic        wb_ack_o,      // ack
    input wire logic        wb_err_o,      // error
    input wire logic        neg_done_i,    // negotiation
    input wire logic        rate_fast_i,   // speed
    input wire logic        full_duplex_i, // duplex
    input wire logic        link_up_i,     // link
    input wire logic        mgmt_irq_o,    // interrupt
    input wire logic        event_irq_o    // unit interrupt
);
    logic [15:0] mask_reg;  // shadow mask register
    logic [3:0]  lvl_reg;   // last event levels
    logic [3:0]  quiet_reg; // edges since a level change
    logic [3:0]  lvl;       // event levels now
    logic        rd_stat;   // status read answered
    logic        rd_mask;   // mask read answered
    assign lvl = {neg_done_i, rate_fast_i, full_duplex_i, link_up_i};
    assign rd_stat = wb_ack_o && !wb_we_i && wb_adr_i == `PHEIU_ADDR_STATUS;
    assign rd_mask = wb_ack_o && !wb_we_i && wb_adr_i == `PHEIU_ADDR_MASK;
    // shadow follows acknowledged mask writes
    always_ff @(posedge sys_clk_i) begin
        if (reset_i)
            mask_reg <= 16'h0000;
        else if (wb_ack_o && wb_we_i && wb_adr_i == `PHEIU_ADDR_MASK)
            mask_reg <= wb_dat_i[15:0] & `PHEIU_MASK_RW_BITS;
    end
    // counts quiet edges on the event levels, saturating
    always_ff @(posedge sys_clk_i) begin
        lvl_reg <= lvl;
        if (reset_i || lvl != lvl_reg)
            quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF)
            quiet_reg <= quiet_reg + 4'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_force_irq: assert property (mask_reg[0] [*3] |-> mgmt_irq_o)
        else $error("forced interrupt not driven");
    a_global_off: assert property
        ((!mask_reg[1] && !mask_reg[0]) [*3] |-> !mgmt_irq_o)
        else $error("interrupt while disabled");
    a_mask_gates: assert property
        ((mask_reg[7:4] == 4'h0 && !mask_reg[0]) [*3] |-> !mgmt_irq_o)
        else $error("interrupt with all events masked");
    a_pend_bit: assert property
        (rd_stat |-> wb_dat_o[2] == mgmt_irq_o)
        else $error("pending bit differs from interrupt");
    a_stat_reserved: assert property
        (rd_stat |-> wb_dat_o[31:8] == 24'h000000 && !wb_dat_o[3])
        else $error("status reserved bits set");
    a_read_clears: assert property
        (rd_stat && quiet_reg > 4'h7 && !mask_reg[0] |-> ##2 !mgmt_irq_o)
        else $error("status read left interrupt active");
    a_mask_back: assert property
        (rd_mask |-> wb_dat_o == {16'h0000, mask_reg})
        else $error("mask readback wrong");
    a_link_flag: assert property
        ($changed(link_up_i) && mask_reg[4] && mask_reg[1]
         |-> ##[2:6] mgmt_irq_o)
        else $error("link change raised no interrupt");
endmodule : pheiu_irq_checker

// [verif/pheiu_mgmt_master.sv]
// Purpose: management controller model, classic Wishbone master
// Assumes: one request at a time on both low byte lanes
// Notes:   idles one cycle plus zero to two more at random before each request
`timescale 1ns/1ps
`include "pheiu_defines.svh"
module pheiu_mgmt_master (
    input  wire logic        sys_clk_i, // device clock
    input  wire logic [31:0] dat_i,     // read data
    input  wire logic        ack_i,     // acknowledge
    input  wire logic        err_i,     // error answer
    output logic             cyc_o,     // bus cycle
    output logic             stb_o,     // strobe
    output logic             we_o,      // write enable
    output logic      [7:0]  adr_o,     // byte address
    output logic      [3:0]  sel_o,     // byte lanes
    output logic      [31:0] dat_o      // write data
);
    // bus idle at time zero
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // one classic cycle, held until ack or err is sampled
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [15:0] d, output logic [31:0] r,
                        output logic er);
        if (a == `PHEIU_ADDR_MASK)
            d = d & 16'h00F3;
        repeat ($urandom_range(2)) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o} <= {2'b11, we, a, 4'h3};
        dat_o <= {16'h0000, d};
        do begin
            @(posedge sys_clk_i);
        end while (!ack_i && !err_i);
        r = dat_i;
        er = err_i;
        {cyc_o, stb_o} <= 2'b00;
        dat_o <= ~dat_o; // released data no longer shows the last value
    endtask : xfer
endmodule : pheiu_mgmt_master

// [verif/test_phy_event_interrupt_unit.sv]
// Purpose: self-checking bench of the event interrupt unit
// Assumes: byte address 0x00 is unmapped and answers with err
// Notes:   reads queue their expected data for the monitor
`timescale 1ns/1ps
`include "pheiu_defines.svh"
module test_phy_event_interrupt_unit;
    localparam logic [7:0] adr_m = `PHEIU_ADDR_MASK;      // mask
    localparam logic [7:0] adr_s = `PHEIU_ADDR_STATUS;    // status
    localparam logic [7:0] adr_e = `PHEIU_ADDR_EVENT_IRQ; // unit sticky
    localparam logic [7:0] adr_k = `PHEIU_ADDR_EVENT_MSK; // unit mask
    logic        sys_clk_i = 1'b0;   // device clock
    logic        reset_i   = 1'b1;   // sync reset
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o; // bus
    logic [7:0]  wb_adr_i;           // byte address
    logic [3:0]  wb_sel_i;           // byte lanes
    logic [31:0] wb_dat_i, wb_dat_o; // bus data
    logic        mgmt_irq_o, event_irq_o; // interrupts
    logic        neg_done_i, rate_fast_i, full_duplex_i, link_up_i;
    logic [3:0]  lvl = 4'h0;         // event levels, link at bit 0
    logic [32:0] exp_q[$];           // expected reads, top bit compares
    logic [32:0] note;               // oldest note
    logic [31:0] rdat;               // direct read data
    logic        rerr;               // direct error answer
    logic [15:0] s, m;               // status and mask values
    int          err_total = 0;      // mismatches
    int          checks_done = 0;    // comparisons
    int          i, p;               // loop indices
    assign {neg_done_i, rate_fast_i, full_duplex_i, link_up_i} = lvl;
    always #50 sys_clk_i = ~sys_clk_i;
    pheiu_irq_unit dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .neg_done_i(neg_done_i), .rate_fast_i(rate_fast_i),
        .full_duplex_i(full_duplex_i), .link_up_i(link_up_i),
        .mgmt_irq_o(mgmt_irq_o), .event_irq_o(event_irq_o));
    pheiu_mgmt_master mst_u (.sys_clk_i(sys_clk_i), .dat_i(wb_dat_o),
        .ack_i(wb_ack_o), .err_i(wb_err_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i),
        .sel_o(wb_sel_i), .dat_o(wb_dat_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk
    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        mst_u.xfer(1'b1, a, d, rdat, rerr);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        mst_u.xfer(1'b0, a, 16'h0000, rdat, rerr);
    endtask : rd
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // monitor: each read answer takes the oldest note
    always @(posedge sys_clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            note = exp_q.pop_front();
            if (note[32])
                chk(wb_dat_o, note[31:0]);
        end
    end
    // watchdog, well past the expected run
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(32'h0B882880));
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd(adr_m, 33'h100000000);
        wr(adr_s, 16'hFFFF);
        rd(adr_s, 33'h100000000);
        mst_u.xfer(1'b0, 8'h00, 16'h0000, rdat, rerr);
        chk1(rerr, 1'b1);
        chk1(mgmt_irq_o, 1'b0);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            m = 16'($urandom());
            wr(adr_m, m);
            rd(adr_m, {17'h10000, m & 16'h00F3});
        end
        $display("test mask done");
        // each event: enabled, masked, then unmasked with global off
        for (i = 0; i < 4; i++)
            for (p = 0; p < 3; p++) begin
                m = (p == 2) ? 16'h0000 : 16'h0002;
                if (p != 1)
                    m[4 + i] = 1'b1;
                wr(adr_m, m);
                lvl[i] <= (p != 1);
                repeat (8) @(posedge sys_clk_i);
                s = 16'h0000;
                s[4 + i] = (i != 3) || (p != 1);
                s[2] = (p == 0);
                chk1(mgmt_irq_o, s[2]);
                rd(adr_s, {17'h10000, s});
                repeat (3) @(posedge sys_clk_i);
                chk1(mgmt_irq_o, 1'b0);
            end
        $display("test events done");
        rd(adr_e, 33'h000000000);
        wr(adr_k, 16'h0001);
        wr(adr_m, 16'h0001);
        repeat (4) @(posedge sys_clk_i);
        chk1(mgmt_irq_o, 1'b1);
        chk1(event_irq_o, 1'b1);
        rd(adr_s, 33'h100000004);
        wr(adr_k, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
        chk1(event_irq_o, 1'b0);
        wr(adr_k, 16'h0001);
        repeat (2) @(posedge sys_clk_i);
        chk1(event_irq_o, 1'b1);
        rd(adr_e, 33'h100000001);
        repeat (2) @(posedge sys_clk_i);
        chk1(event_irq_o, 1'b0);
        wr(adr_m, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        chk1(mgmt_irq_o, 1'b0);
        $display("test force done");
        // mid-run reset with every level high: no false events
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rd(adr_s, 33'h100000000);
        rd(adr_m, 33'h100000000);
        chk1(mgmt_irq_o, 1'b0);
        $display("test second reset done");
        conclude();
    end
endmodule : test_phy_event_interrupt_unit
bind pheiu_irq_unit pheiu_irq_checker chk_u (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .neg_done_i(neg_done_i),
    .rate_fast_i(rate_fast_i), .full_duplex_i(full_duplex_i),
    .link_up_i(link_up_i), .mgmt_irq_o(mgmt_irq_o),
    .event_irq_o(event_irq_o));
